// File: hdl/cpm_pkg.sv
// Shared constants, encodings and carrier types of the core and its address map
package cpm_pkg;

   // ---------------------------------------------------------------
   // Address widths and data-space map
   // ---------------------------------------------------------------
   localparam int          PC_W          = 23;
   localparam int          DA_W          = 24;
   localparam logic [23:0] IO_DIRECT_END = 24'h00003F;
   localparam logic [23:0] XIO_END       = 24'h000FFF;
   localparam logic [23:0] EEMAP_START   = 24'h001000;
   localparam logic [23:0] EEMAP_END     = 24'h001FFF;
   localparam logic [23:0] SRAM_START    = 24'h002000;
   localparam logic [23:0] SRAM_END      = 24'h003FFF;
   localparam logic [23:0] XRAM_END      = 24'h7FFFFF;
   localparam logic [15:0] SP_RESET      = 16'h3FFF;

   // ---------------------------------------------------------------
   // Core-internal I/O registers
   // ---------------------------------------------------------------
   localparam logic [5:0]  IOA_DEXT      = 6'h3B;
   localparam logic [5:0]  IOA_SPL       = 6'h3D;
   localparam logic [5:0]  IOA_SPH       = 6'h3E;
   localparam logic [5:0]  IOA_SREG      = 6'h3F;

   // ---------------------------------------------------------------
   // Program memory sections (word addresses), return size, pointer and source registers, addressing modes
   // ---------------------------------------------------------------
   localparam int          PM_BYTES      = 270336;
   localparam int          RET_LIMIT     = 131072;
   localparam logic [1:0]  RET_BYTES     = (PM_BYTES <= RET_LIMIT) ? 2'h2 : 2'h3;
   localparam logic [22:0] TBL_START     = 23'h01F000;
   localparam logic [22:0] BOOT_START    = 23'h020000;
   localparam logic [4:0]  PTR_BASE      = 5'h1A;
   localparam logic [4:0]  SPM_SRC_REG   = 5'h00;
   localparam logic [1:0]  MODE_POSTINC  = 2'h1;
   localparam logic [1:0]  MODE_PREDEC   = 2'h2;

   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_RUN = 2'b00, ST_LOAD = 2'b01, ST_RET = 2'b10} cpm_state_e;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_ALU_RR = 4'h1, OP_ADDI = 4'h2, OP_SUBI = 4'h3, OP_ANDI = 4'h4,
      OP_LDI = 4'h5, OP_SINGLE = 4'h6, OP_IO = 4'h7, OP_MEM = 4'h8, OP_RJMP = 4'h9,
      OP_RCALL = 4'hA, OP_RET = 4'hB, OP_IJMP = 4'hC, OP_SPM = 4'hD
   } cpm_op_e;

   typedef enum logic [3:0] {
      ALU_ADD = 4'h0, ALU_SUB = 4'h1, ALU_AND = 4'h2, ALU_OR = 4'h3, ALU_MOV = 4'h4,
      ALU_INC = 4'h5, ALU_DEC = 4'h6, ALU_COM = 4'h7, ALU_LSR = 4'h8
   } cpm_alu_e;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {logic v; logic n; logic z; logic c;} cpm_sreg_s;
   typedef struct packed {logic xram; logic sram; logic eemap; logic xio; logic io;} cpm_dsel_s;
   typedef struct packed {logic boot_wr; logic tbl_rd; logic tbl_wr; logic app_rd; logic app_wr;} cpm_lock_s;
   typedef struct packed {logic wr; logic [22:0] addr; logic [15:0] data;} cpm_nvm_s;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [23:0] addr;
      logic [1:0]  size;
      logic [23:0] wdata;
   } cpm_dreq_s;

   typedef struct packed {logic [31:0][7:0] r;} cpm_rf_s;

   typedef struct packed {
      cpm_state_e  st;
      logic [22:0] pc;
      logic [22:0] xpc;
      logic [15:0] ir;
      logic        irv;
      cpm_sreg_s   sreg;
      logic [15:0] sp;
      logic [7:0]  dext;
      cpm_dreq_s   dreq;
      cpm_dsel_s   dsel;
      logic        ld_int;
      logic [23:0] ld_intv;
      logic [4:0]  ld_rd;
      logic [1:0]  ld_size;
      cpm_nvm_s    nvm;
      logic        spm_denied;
   } cpm_core_s;

endpackage

// File: hdl/cpm_regfile.sv
// Working register file: 32 bytes, two read ports, one write port of up to three bytes
`timescale 1ns/1ns
module cpm_regfile
   import cpm_pkg::*;
(
   input  wire logic             i_mclk,
   input  wire logic             i_nrst,
   input  wire logic [4:0]       i_ra,
   input  wire logic [4:0]       i_rb,
   input  wire logic [2:0]       i_we,
   input  wire logic [4:0]       i_wa,
   input  wire logic [23:0]      i_wd,
   output logic      [23:0]      o_qa,
   output logic      [7:0]       o_qb,
   output logic      [2:0][15:0] o_ptr
);

   cpm_rf_s               rf_q;
   cpm_rf_s               rf_d;
   logic     [31:0][7:0]  nxt;

   // ---------------------------------------------------------------
   // Per-register write select
   // ---------------------------------------------------------------
   for (genvar gi = 0; gi < 32; gi++)
   begin : g_reg
      logic [4:0] off;
      assign off     = 5'(gi) - i_wa;
      assign nxt[gi] = (off < 5'h3 && i_we[off[1:0]]) ? i_wd[{off[1:0], 3'h0} +: 8] : rf_q.r[gi];
   end

   for (genvar gp = 0; gp < 3; gp++)
   begin : g_ptr
      assign o_ptr[gp] = {rf_q.r[PTR_BASE + 5'(2 * gp + 1)], rf_q.r[PTR_BASE + 5'(2 * gp)]};
   end

   // Both operands come out in the same cycle, so one instruction reads two registers
   assign o_qa = {rf_q.r[5'(i_ra + 5'h2)], rf_q.r[5'(i_ra + 5'h1)], rf_q.r[i_ra]};
   assign o_qb = rf_q.r[i_rb];

   always_comb
   begin
      rf_d   = rf_q;
      rf_d.r = nxt;
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         rf_q <= '0;
      else
         rf_q <= rf_d;
   end

   a_rf_write_lands: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      i_we[0] |=> rf_q.r[$past(i_wa)] == $past(i_wd[7:0]))
      else $error("register write did not land");

endmodule

// File: hdl/cpm_core.sv
// Core: prefetching execution pipe, ALU, stack and data-space address decoder
`timescale 1ns/1ns
module cpm_core
   import cpm_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_nrst,
   output logic      [22:0] o_pm_addr,
   input  wire logic [15:0] i_pm_data,
   output cpm_dreq_s        o_dm,
   output cpm_dsel_s        o_dm_sel,
   input  wire logic [23:0] i_dm_rdata,
   input  wire logic        i_eemap_en,
   input  wire cpm_lock_s   i_lock,
   output cpm_nvm_s         o_nvm,
   output cpm_sreg_s        o_sreg,
   output logic             o_spm_denied
);

   cpm_core_s          st_q;
   cpm_core_s          st_d;
   logic      [4:0]    rf_ra;
   logic      [4:0]    rf_rb;
   logic      [4:0]    rf_wa;
   logic      [2:0]    rf_we;
   logic      [23:0]   rf_wd;
   logic      [23:0]   rf_qa;
   logic      [7:0]    rf_qb;
   logic [2:0][15:0]   rf_ptr;
   logic      [3:0]    ex_op;
   logic      [4:0]    rd5;
   logic      [3:0]    alu_sel;
   logic      [7:0]    opb;
   logic      [11:0]   alu_out;
   logic               acc_rd;
   logic               acc_wr;
   logic               acc_ret;
   logic      [23:0]   acc_addr;
   logic      [1:0]    acc_size;
   logic      [23:0]   acc_wd;
   logic      [1:0]    psel;
   logic      [1:0]    sz;
   logic      [15:0]   ptr_new;
   logic      [22:0]   spm_tgt;
   logic               spm_lock;
   logic               int_hit;
   logic      [23:0]   int_val;
   logic      [23:0]   rd_val;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [11:0] alu_f(input logic [3:0] f, input logic [7:0] a, input logic [7:0] b,
                                         input logic c_in);
      logic [8:0] w;
      logic       v;
      w = 9'h000;
      v = 1'b0;
      case (f)
         ALU_ADD: begin w = {1'b0, a} + {1'b0, b}; v = (a[7] == b[7]) && (w[7] != a[7]); end
         ALU_SUB: begin w = {1'b0, a} - {1'b0, b}; v = (a[7] != b[7]) && (w[7] != a[7]); end
         ALU_AND: w = {1'b0, a & b};
         ALU_OR:  w = {1'b0, a | b};
         ALU_MOV: w = {c_in, b};
         ALU_INC: begin w = {c_in, 8'(a + 8'h01)}; v = (a == 8'h7F); end
         ALU_DEC: begin w = {c_in, 8'(a - 8'h01)}; v = (a == 8'h80); end
         ALU_COM: w = {1'b1, ~a};
         ALU_LSR: w = {a[0], 1'b0, a[7:1]};
         default: w = {c_in, a};
      endcase
      return {v, w[7], w[7:0] == 8'h00, w[8], w[7:0]};
   endfunction

   // Region decode; a disabled EEPROM window decodes to nothing and reads as zero
   function automatic cpm_dsel_s dec_f(input logic [23:0] a, input logic ee);
      cpm_dsel_s s;
      s = '0;
      if (a <= IO_DIRECT_END)
         s.io = 1'b1;
      else if (a <= XIO_END)
         s.xio = 1'b1;
      else if (a <= EEMAP_END)
         s.eemap = ee;
      else if (a <= SRAM_END)
         s.sram = 1'b1;
      else if (a <= XRAM_END)
         s.xram = 1'b1;
      return s;
   endfunction

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   cpm_regfile u_rf (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_ra   (rf_ra),
      .i_rb   (rf_rb),
      .i_we   (rf_we),
      .i_wa   (rf_wa),
      .i_wd   (rf_wd),
      .o_qa   (rf_qa),
      .o_qb   (rf_qb),
      .o_ptr  (rf_ptr)
   );

   // ---------------------------------------------------------------
   // Decode fields and internal register view
   // ---------------------------------------------------------------
   assign ex_op   = (st_q.st == ST_RUN && st_q.irv) ? st_q.ir[15:12] : OP_NOP;
   assign rd5     = st_q.ir[4:0];
   assign rf_rb   = st_q.ir[9:5];
   assign psel    = (st_q.ir[11:10] == 2'h3) ? 2'h2 : st_q.ir[11:10];
   assign sz      = (st_q.ir[7:6] == 2'h0) ? 2'h1 : st_q.ir[7:6];
   assign ptr_new = (st_q.ir[9:8] == MODE_PREDEC) ? rf_ptr[psel] - {14'h0000, sz}
                                                  : rf_ptr[psel] + {14'h0000, sz};
   assign spm_tgt = {st_q.dext[6:0], rf_ptr[2]};
   assign spm_lock = (spm_tgt >= BOOT_START) ? i_lock.boot_wr :
                     (spm_tgt >= TBL_START)  ? (i_lock.tbl_wr | i_lock.tbl_rd)
                                             : (i_lock.app_wr | i_lock.app_rd);
   assign int_hit = (acc_addr[23:6] == 18'h00000) &&
                    (acc_addr[5:0] == IOA_DEXT || acc_addr[5:0] == IOA_SPL ||
                     acc_addr[5:0] == IOA_SPH  || acc_addr[5:0] == IOA_SREG);
   // Stack pointer and status sit side by side, so a wide read sees them in one go
   assign int_val = (acc_addr[5:0] == IOA_SPL) ? {4'h0, st_q.sreg, st_q.sp} :
                    (acc_addr[5:0] == IOA_SPH) ? {12'h000, st_q.sreg, st_q.sp[15:8]} :
                    (acc_addr[5:0] == IOA_SREG) ? {20'h00000, st_q.sreg} : {16'h0000, st_q.dext};
   assign rd_val  = st_q.ld_int ? st_q.ld_intv :
                    (st_q.dsel == '0) ? 24'h000000 : i_dm_rdata;
   assign opb     = (ex_op >= OP_ADDI && ex_op <= OP_LDI) ? st_q.ir[7:0] : rf_qb;
   assign alu_out = alu_f(alu_sel, rf_qa[7:0], opb, st_q.sreg.c);

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb
   begin
      st_d            = st_q;
      st_d.dreq.rd    = 1'b0;
      st_d.dreq.wr    = 1'b0;
      st_d.nvm.wr     = 1'b0;
      st_d.spm_denied = 1'b0;
      rf_ra    = rd5;
      rf_we    = 3'h0;
      rf_wa    = rd5;
      rf_wd    = 24'h000000;
      alu_sel  = ALU_MOV;
      acc_rd   = 1'b0;
      acc_wr   = 1'b0;
      acc_ret  = 1'b0;
      acc_addr = 24'h000000;
      acc_size = 2'h1;
      acc_wd   = rf_qa;
      case (st_q.st)
         ST_RUN:
         begin
            // The next word is taken while the current one executes
            st_d.pc   = 23'(st_q.pc + 23'h1);
            st_d.xpc  = st_q.pc;
            st_d.ir   = i_pm_data;
            st_d.irv  = 1'b1;
            st_d.dsel = '0;
            case (ex_op)
               OP_ALU_RR, OP_ADDI, OP_SUBI, OP_ANDI, OP_LDI, OP_SINGLE:
               begin
                  if (ex_op == OP_ALU_RR)
                     alu_sel = {2'h0, st_q.ir[11:10]};
                  else if (ex_op == OP_SINGLE)
                     alu_sel = 4'(ALU_INC + {2'h0, st_q.ir[6:5]});
                  else if (ex_op == OP_LDI)
                     alu_sel = ALU_MOV;
                  else
                     alu_sel = 4'(ex_op - OP_ADDI);
                  if (ex_op != OP_ALU_RR && ex_op != OP_SINGLE)
                     rf_ra = {1'b1, st_q.ir[11:8]};
                  rf_we = 3'h1;
                  rf_wa = rf_ra;
                  rf_wd = {16'h0000, alu_out[7:0]};
                  if (alu_sel != ALU_MOV)
                     st_d.sreg = alu_out[11:8];
               end
               OP_IO:
               begin
                  // Only six address bits, so direct I/O never reaches past the first 64
                  acc_addr = {18'h00000, st_q.ir[10:5]};
                  acc_wr   = st_q.ir[11];
                  acc_rd   = !st_q.ir[11];
               end
               OP_MEM:
               begin
                  acc_addr = {st_q.dext, (st_q.ir[9:8] == MODE_PREDEC) ? ptr_new : rf_ptr[psel]};
                  acc_size = sz;
                  acc_wr   = st_q.ir[5];
                  acc_rd   = !st_q.ir[5];
                  if (st_q.ir[9:8] == MODE_POSTINC || st_q.ir[9:8] == MODE_PREDEC)
                  begin
                     rf_we = 3'h3;
                     rf_wa = 5'(PTR_BASE + {2'h0, psel, 1'b0});
                     rf_wd = {8'h00, ptr_new};
                  end
               end
               OP_RJMP, OP_RCALL:
               begin
                  st_d.pc  = 23'(st_q.xpc + 23'h1 + {{11{st_q.ir[11]}}, st_q.ir[11:0]});
                  st_d.irv = 1'b0;
                  if (ex_op == OP_RCALL)
                  begin
                     acc_wr   = 1'b1;
                     acc_size = RET_BYTES;
                     acc_addr = 24'({8'h00, st_q.sp} - {22'h000000, RET_BYTES} + 24'h000001);
                     acc_wd   = {1'b0, 23'(st_q.xpc + 23'h1)};
                     st_d.sp  = 16'(st_q.sp - {14'h0000, RET_BYTES});
                  end
               end
               OP_RET:
               begin
                  acc_rd   = 1'b1;
                  acc_ret  = 1'b1;
                  acc_size = RET_BYTES;
                  acc_addr = 24'({8'h00, st_q.sp} + 24'h000001);
                  st_d.sp  = 16'(st_q.sp + {14'h0000, RET_BYTES});
                  st_d.irv = 1'b0;
               end
               OP_IJMP:
               begin
                  st_d.pc  = spm_tgt;
                  st_d.irv = 1'b0;
               end
               OP_SPM:
               begin
                  // Only code running from the boot section may store into flash
                  rf_ra = SPM_SRC_REG;
                  if (st_q.xpc >= BOOT_START && !spm_lock)
                  begin
                     st_d.nvm.wr   = 1'b1;
                     st_d.nvm.addr = spm_tgt;
                     st_d.nvm.data = rf_qa[15:0];
                  end
                  else
                     st_d.spm_denied = 1'b1;
               end
               default:
               begin
               end
            endcase
            if (acc_rd || acc_wr)
            begin
               if (int_hit)
               begin
                  if (acc_wr)
                  begin
                     case (acc_addr[5:0])
                        IOA_DEXT: st_d.dext = acc_wd[7:0];
                        IOA_SPL:
                        begin
                           st_d.sp[7:0] = acc_wd[7:0];
                           if (acc_size != 2'h1)
                              st_d.sp[15:8] = acc_wd[15:8];
                        end
                        IOA_SPH:  st_d.sp[15:8] = acc_wd[7:0];
                        default:  st_d.sreg = acc_wd[3:0];
                     endcase
                  end
               end
               else
               begin
                  st_d.dreq.rd    = acc_rd;
                  st_d.dreq.wr    = acc_wr;
                  st_d.dreq.addr  = acc_addr;
                  st_d.dreq.size  = acc_size;
                  st_d.dreq.wdata = acc_wd;
                  st_d.dsel       = dec_f(acc_addr, i_eemap_en);
               end
               if (acc_rd)
               begin
                  st_d.ld_int  = int_hit;
                  st_d.ld_intv = int_val;
                  st_d.ld_rd   = rd5;
                  st_d.ld_size = acc_size;
                  st_d.st      = acc_ret ? ST_RET : ST_LOAD;
               end
            end
         end
         ST_LOAD:
         begin
            // Fetch and the prefetched word hold for this one cycle
            rf_we     = {st_q.ld_size == 2'h3, st_q.ld_size != 2'h1, 1'b1};
            rf_wa     = st_q.ld_rd;
            rf_wd     = rd_val;
            st_d.dsel = '0;
            st_d.st   = ST_RUN;
         end
         ST_RET:
         begin
            st_d.pc   = rd_val[22:0];
            st_d.dsel = '0;
            st_d.st   = ST_RUN;
         end
         default:
            st_d.st = ST_RUN;
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         st_q    <= '0;
         st_q.sp <= SP_RESET;
      end
      else
         st_q <= st_d;
   end

   assign o_pm_addr    = st_q.pc;
   assign o_dm         = st_q.dreq;
   assign o_dm_sel     = st_q.dsel;
   assign o_nvm        = st_q.nvm;
   assign o_sreg       = st_q.sreg;
   assign o_spm_denied = st_q.spm_denied;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_reset_fetch_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      $rose(i_nrst) |-> o_pm_addr == 23'h000000 && !st_q.irv)
      else $error("fetch did not start at zero");

   a_fetch_every_cycle: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      ex_op == OP_ALU_RR |=> st_q.irv && o_pm_addr == 23'($past(o_pm_addr) + 23'h1))
      else $error("prefetch stalled on a plain instruction");

   a_alu_zero_flag: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      ex_op == OP_ALU_RR |=> o_sreg.z == ($past(alu_out[7:0]) == 8'h00))
      else $error("zero flag does not match result");

   a_io_low_space: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (o_dm.rd || o_dm.wr) && o_dm.addr <= XIO_END |-> (o_dm_sel.io || o_dm_sel.xio))
      else $error("low space not routed to I/O");

   a_io_direct_path: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      ex_op == OP_IO && !int_hit |=> (o_dm.rd || o_dm.wr) && o_dm_sel.io)
      else $error("direct I/O access missed the I/O region");

   a_ee_window_sel: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (o_dm.rd || o_dm.wr) && o_dm.addr >= EEMAP_START && o_dm.addr <= EEMAP_END
      |-> o_dm_sel.eemap == $past(i_eemap_en) && !o_dm_sel.sram)
      else $error("EEPROM window decoded wrongly");

   a_sram_base_addr: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_dm_sel.sram |-> o_dm.addr >= SRAM_START && o_dm.addr <= SRAM_END)
      else $error("SRAM selected outside its range");

   a_unmapped_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      st_q.st == ST_LOAD && !st_q.ld_int && st_q.dsel == '0 |-> rf_we[0] && rf_wd == 24'h000000)
      else $error("unmapped read returned nonzero");

   a_spm_from_boot: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_nvm.wr |-> $past(st_q.xpc) >= BOOT_START)
      else $error("flash store issued outside boot section");

   a_call_push_size: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      ex_op == OP_RCALL |=> o_dm.wr && o_dm.size == RET_BYTES &&
                            st_q.sp == 16'($past(st_q.sp) - {14'h0000, RET_BYTES}))
      else $error("call pushed wrong return size");

endmodule

// File: dv/cpm_mem.sv
// Program and data memory model facing the core
`timescale 1ns/1ns
module cpm_mem
   import cpm_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic [22:0] i_pm_addr,
   input  wire cpm_dreq_s   i_dm,
   input  wire cpm_dsel_s   i_dm_sel,
   output logic      [15:0] o_pm_data,
   output logic      [23:0] o_dm_rdata
);
   logic [15:0] rom [64];
   logic [7:0]  ram [256];
   logic [23:0] last_q;
   logic [7:0]  ra;
   assign ra = i_dm.addr[7:0];
   // Code comes only from rom, on its own bus
   assign o_pm_data = rom[i_pm_addr[5:0]];
   // Idle read bus shows the inverse of the last value read, never a stale copy
   assign o_dm_rdata = i_dm.rd ? {ram[ra + 8'h2], ram[ra + 8'h1], ram[ra]} : ~last_q;
   always_ff @(posedge i_mclk)
   begin
      if (i_dm.rd)
         last_q <= o_dm_rdata;
      // Wide stores land all their bytes, so a pushed return address pops back whole
      for (int k = 0; k < 3; k++)
         if (i_dm.wr && i_dm_sel.sram && k < int'(i_dm.size))
            ram[8'(ra + 8'(k))] <= i_dm.wdata[8 * k +: 8];
   end
endmodule

// File: dv/cpm_core_test.sv
// Self-checking bench: random sums and flags, reload, closed window, call and return, refused flash store
`timescale 1ns/1ns
module cpm_core_test;
   import cpm_pkg::*;
   localparam int N = 12;
   localparam int P = 2 + 4 * N;
   logic        i_mclk = 1'b0;
   logic        i_nrst = 1'b0;
   logic        eemap_en = 1'b0;
   cpm_lock_s   lock = '0;
   logic [22:0] pm_addr;
   logic [15:0] pm_data;
   cpm_dreq_s   dm;
   cpm_dsel_s   dm_sel;
   logic [23:0] dm_rdata;
   cpm_nvm_s    nvm;
   logic        denied;
   cpm_sreg_s   sreg;
   logic [36:0] notes [$];
   int          miscompares = 0;
   int          checks = 0;
   int          cycles = 0;
   logic [7:0]  a;
   logic [7:0]  b;
   logic [8:0]  s;
   logic [3:0]  fl;

   cpm_core DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .o_pm_addr(pm_addr), .i_pm_data(pm_data), .o_dm(dm),
      .o_dm_sel(dm_sel), .i_dm_rdata(dm_rdata), .i_eemap_en(eemap_en), .i_lock(lock), .o_nvm(nvm),
      .o_sreg(sreg), .o_spm_denied(denied));
   cpm_mem mem (.i_mclk(i_mclk), .i_pm_addr(pm_addr), .i_dm(dm), .i_dm_sel(dm_sel), .o_pm_data(pm_data),
      .o_dm_rdata(dm_rdata));

   initial forever #5 i_mclk = ~i_mclk;

   task automatic compare_value(input string what, input logic [36:0] exp, input logic [36:0] got);
      checks++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   task automatic compare_pulse(input string what, input logic exp, input logic got);
      compare_value(what, 37'(exp), 37'(got));
   endtask

   task automatic wrap_up;
      if (notes.size() != 0)
         miscompares++;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Watcher: outputs are flops, so look at them mid-cycle
   // ---------------------------------------------------------------
   always @(negedge i_mclk)
   begin
      cycles++;
      if (dm.wr === 1'b1)
         compare_value("store", notes.pop_front(), {dm_sel.sram, dm.addr, dm.wdata[7:0], sreg});
      if (denied === 1'b1)
         compare_pulse("refusal", 1'b0, notes.pop_front() != 37'h0);
      if (nvm.wr === 1'b1)
         compare_pulse("flash write", 1'b0, 1'b1);
      if (cycles == 2000)
      begin
         miscompares++;
         wrap_up;
      end
   end

   initial
   begin
      void'($urandom(33));
      mem.rom[0] = 16'h5A00;
      mem.rom[1] = 16'h5B20;
      for (int i = 0; i < N; i++)
      begin
         a = 8'($urandom);
         b = 8'($urandom);
         s = 9'(a) + 9'(b);
         // Flags of an add: overflow, negative, zero, carry
         fl = {(a[7] == b[7]) && (s[7] != a[7]), s[7], s[7:0] == 8'h00, s[8]};
         mem.rom[2 + 4 * i] = {8'h50, a};
         mem.rom[3 + 4 * i] = {8'h51, b};
         mem.rom[4 + 4 * i] = 16'h1230;
         // Post-increment store, so each sum lands one byte higher
         mem.rom[5 + 4 * i] = 16'h8130;
         notes.push_back({1'b1, 24'h002000 + 24'(i), s[7:0], fl});
      end
      // Pre-decrement reload of the last sum, stored back over itself; loads leave flags alone
      mem.rom[P] = 16'h8212;
      mem.rom[P + 1] = 16'h8132;
      notes.push_back({1'b1, 24'h002000 + 24'(N - 1), s[7:0], fl});
      // Read through the closed EEPROM window gives zero, whatever the bus shows
      mem.rom[P + 2] = 16'h5C00;
      mem.rom[P + 3] = 16'h5D10;
      mem.rom[P + 4] = 16'h8413;
      mem.rom[P + 5] = 16'h8133;
      notes.push_back({1'b1, 24'h002000 + 24'(N), 8'h00, fl});
      // Call pushes a full return address below the stack top, return pops it
      mem.rom[P + 6] = 16'hA002;
      notes.push_back({1'b1, 24'(SP_RESET) - 24'(RET_BYTES) + 24'h000001, 8'(P + 7), fl});
      mem.rom[P + 9] = 16'hB000;
      // Flash store placed outside the boot section; software must not, so it is refused
      mem.rom[P + 7] = 16'hD000;
      notes.push_back(37'h0);
      mem.rom[P + 8] = 16'h9FFF;
      repeat (16) @(negedge i_mclk);
      compare_value("fetch address", 37'h0, 37'(pm_addr));
      i_nrst = 1'b1;
      repeat (4 * N + 40) @(negedge i_mclk);
      $display("test sums and refused store done");
      wrap_up;
   end
endmodule
